/* uart_core_pkg.sv */
// shared constants, state enumerations and helper functions of the serial core
package uart_core_pkg;

  // ---------------------------------------------------------------------------
  // character format
  // ---------------------------------------------------------------------------
  localparam int DATA_BITS = 8;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic LINE_IDLE = 1'b1;

  // ---------------------------------------------------------------------------
  // oversampling: sixteen baud ticks make one bit time
  // ---------------------------------------------------------------------------
  localparam int OVERSAMPLE = 16;
  localparam logic [3:0] TICK_LAST = 4'hF;
  localparam logic [3:0] TICK_MID = 4'h7;
  localparam logic [15:0] BAUD_DIV_RESET = 16'h0000;

  // ---------------------------------------------------------------------------
  // address handling schemes in nine-bit operation
  // ---------------------------------------------------------------------------
  localparam logic [1:0] SCHEME_ALL = 2'h0;
  localparam logic [1:0] SCHEME_ADDR_ONLY = 2'h1;
  localparam logic [1:0] SCHEME_MATCH = 2'h2;
  localparam logic [1:0] SCHEME_MATCH_DATA = 2'h3;

  // ---------------------------------------------------------------------------
  // state machines
  // ---------------------------------------------------------------------------
  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_NINTH, TX_STOP} tx_state_type;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_NINTH, RX_STOP} rx_state_type;

  // parity bit that makes data plus parity even (odd = 0) or odd (odd = 1)
  function automatic logic parity_of(input logic [7:0] data, input logic odd);
    return (^data) ^ odd;
  endfunction

endpackage

/* baud_tick_gen.sv */
// programmable divider that makes the sixteen-per-bit oversampling tick
`timescale 1ns/10ps
module baud_tick_gen #(
  parameter int DIV_WIDTH = 16
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // divisor
  input wire logic [DIV_WIDTH-1:0] i_divisor,
  // tick
  output logic o_tick
);

  typedef struct packed {
    logic [DIV_WIDTH-1:0] count;
    logic tick;
  } baud_state_type;

  baud_state_type st;
  baud_state_type next_st;

  // count down to zero, then reload; a zero divisor stops the ticks
  always_comb begin
    next_st = st;
    next_st.tick = 1'b0;
    if (st.count == '0) begin
      next_st.count = i_divisor - {{(DIV_WIDTH-1){1'b0}}, 1'b1};
      next_st.tick = (i_divisor != '0);
    end else begin
      next_st.count = st.count - {{(DIV_WIDTH-1){1'b0}}, 1'b1};
    end
    if (i_divisor == '0) begin
      next_st.count = '0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign o_tick = st.tick;

endmodule

/* async_serial_txrx_core.sv */
// asynchronous serial transmitter and receiver with plain control and status ports
`timescale 1ns/10ps

// How it works
// - eight data bits, lsb first, both directions
// - low start bit, one or two high stop bits
// - optional ninth bit: parity or address marker
// - transmit starts only while enabled
// - parity on and nine-bit off: even or odd parity
// - flow gate on: clear-to-send gates each start
// - holding-empty is 1 when a byte fits, 0 while full
// - a written byte is shifted out by itself
// - nine-bit mode sends the outgoing address flag
// - nine-bit mode only while enabled
// - transmit interrupt follows holding-empty
// - receiver starts a character only while enabled
// - byte-waiting is 1 while a received byte is held
// - receive interrupt on new byte and on errors
// - receive interrupt on data and errors, or errors only
// - separate error, break and data-waiting flags
// - two-bit field selects the address scheme
// - automatic schemes match address bytes to node address
// - sixteen-bit divisor sets the bit rate
// - both directions share baud rate and format
// - clear-to-send sampled four clocks before each start, through the synchroniser
// - marker bit right after the eighth data bit
module async_serial_txrx_core (
  // clock and reset
  input wire logic I_CORE_CLK,
  input wire logic I_RST,
  // line pins
  input wire logic I_RX_SERIAL,
  input wire logic I_CTS_N,
  output logic O_TX_SERIAL,
  // shared configuration
  input wire logic [7:0] I_BAUD_HIGH,
  input wire logic [7:0] I_BAUD_LOW,
  input wire logic I_PARITY_ENABLE_BIT,
  input wire logic I_PARITY_ODD,
  input wire logic I_STOP_TWO,
  input wire logic I_NINE_BIT_ENABLE,
  input wire logic [1:0] I_ADDR_SCHEME_FIELD,
  input wire logic [7:0] I_NODE_ADDR,
  // transmit control
  input wire logic I_TX_ENABLE_BIT,
  input wire logic I_FLOW_GATE_ENABLE,
  input wire logic I_OUTGOING_ADDR_FLAG,
  input wire logic I_TX_IRQ_ENABLE,
  input wire logic I_TX_WRITE,
  input wire logic [7:0] I_TX_DATA,
  // receive control
  input wire logic I_RX_ENABLE,
  input wire logic I_RX_IRQ_ERRORS_ONLY,
  input wire logic I_RX_READ,
  // status
  output logic O_TX_HOLDING_EMPTY,
  output logic O_TX_BUSY,
  output logic O_RX_BYTE_WAITING,
  output logic [7:0] O_RX_DATA,
  output logic O_RX_ADDR_BIT,
  output logic O_RX_NEW_FRAME,
  output logic O_PARITY_ERR,
  output logic O_FRAMING_ERR,
  output logic O_OVERRUN_ERR,
  output logic O_BREAK_SEEN,
  // interrupt requests
  output logic O_TX_IRQ,
  output logic O_RX_IRQ
);

  // ---------------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------------
  typedef struct packed {
    uart_core_pkg::tx_state_type tx_state;
    logic [3:0] tx_tick;
    logic [2:0] tx_bit;
    logic [7:0] tx_shift;
    logic tx_ninth;
    logic tx_line;
    logic [7:0] tx_hold;
    logic tx_hold_addr;
    logic tx_holding_empty;
    logic tx_irq;
    logic [2:0] rx_sync;
    logic [2:0] cts_sync;
    logic rx_level;
    logic cts_level;
    logic rx_armed;
    uart_core_pkg::rx_state_type rx_state;
    logic [3:0] rx_tick;
    logic [2:0] rx_bit;
    logic [7:0] rx_shift;
    logic rx_ninth;
    logic [7:0] rx_data;
    logic rx_addr_bit;
    logic rx_new_frame;
    logic rx_waiting;
    logic [7:0] pend_data;
    logic pend_addr;
    logic pend_new_frame;
    logic pend_valid;
    logic addr_matched;
    logic first_data;
    logic parity_err;
    logic framing_err;
    logic overrun_err;
    logic break_seen;
    logic rx_irq;
  } core_state_type;

  localparam core_state_type ST_RESET = '{
    tx_state: uart_core_pkg::TX_IDLE,
    rx_state: uart_core_pkg::RX_IDLE,
    tx_line: uart_core_pkg::LINE_IDLE,
    tx_holding_empty: 1'b1,
    rx_sync: {3{uart_core_pkg::LINE_IDLE}},
    cts_sync: 3'h7,
    rx_level: uart_core_pkg::LINE_IDLE,
    cts_level: 1'b1,
    default: '0
  };

  core_state_type st;
  core_state_type next_st;
  logic baud_tick;

  // ---------------------------------------------------------------------------
  // baud tick, one generator for both directions
  // ---------------------------------------------------------------------------
  baud_tick_gen #(
    .DIV_WIDTH(16)
  ) u_baud (
    .i_clk(I_CORE_CLK),
    .i_rst(I_RST),
    .i_divisor({I_BAUD_HIGH, I_BAUD_LOW}),
    .o_tick(baud_tick)
  );

  // ---------------------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------------------
  always_comb begin
    logic ninth_used;
    logic rx_is_addr;
    logic rx_accept;
    logic rx_nf;
    logic rx_done;
    logic is_break;
    ninth_used = I_NINE_BIT_ENABLE || I_PARITY_ENABLE_BIT;
    rx_is_addr = 1'b0;
    rx_accept = 1'b0;
    rx_nf = 1'b0;
    rx_done = 1'b0;
    is_break = 1'b0;
    next_st = st;

    // pin synchronisers: a level counts once the second and third stages agree
    next_st.rx_sync = {st.rx_sync[1:0], I_RX_SERIAL};
    next_st.cts_sync = {st.cts_sync[1:0], I_CTS_N};
    if (st.rx_sync[1] == st.rx_sync[2]) begin
      next_st.rx_level = st.rx_sync[2];
    end
    if (st.cts_sync[1] == st.cts_sync[2]) begin
      next_st.cts_level = st.cts_sync[2];
    end

    // transmitter; starts only on a tick so the start bit is a full bit long
    unique case (st.tx_state)
      uart_core_pkg::TX_IDLE: begin
        next_st.tx_line = uart_core_pkg::LINE_IDLE;
        if (baud_tick && !st.tx_holding_empty && I_TX_ENABLE_BIT
            && (!I_FLOW_GATE_ENABLE || !st.cts_level)) begin
          next_st.tx_shift = st.tx_hold;
          next_st.tx_holding_empty = 1'b1;
          if (I_NINE_BIT_ENABLE) begin
            next_st.tx_ninth = st.tx_hold_addr;
          end else begin
            next_st.tx_ninth = uart_core_pkg::parity_of(st.tx_hold, I_PARITY_ODD);
          end
          next_st.tx_state = uart_core_pkg::TX_START;
          next_st.tx_line = 1'b0;
          next_st.tx_tick = '0;
        end
      end
      uart_core_pkg::TX_START: begin
        if (baud_tick) begin
          next_st.tx_tick = st.tx_tick + 4'h1;
          if (st.tx_tick == uart_core_pkg::TICK_LAST) begin
            next_st.tx_state = uart_core_pkg::TX_DATA;
            next_st.tx_line = st.tx_shift[0];
            next_st.tx_bit = '0;
          end
        end
      end
      uart_core_pkg::TX_DATA: begin
        if (baud_tick) begin
          next_st.tx_tick = st.tx_tick + 4'h1;
          if (st.tx_tick == uart_core_pkg::TICK_LAST) begin
            next_st.tx_shift = st.tx_shift >> 1;
            next_st.tx_line = st.tx_shift[1];
            next_st.tx_bit = st.tx_bit + 3'h1;
            if (st.tx_bit == uart_core_pkg::BIT_LAST) begin
              next_st.tx_bit = '0;
              if (ninth_used) begin
                next_st.tx_state = uart_core_pkg::TX_NINTH;
                next_st.tx_line = st.tx_ninth;
              end else begin
                next_st.tx_state = uart_core_pkg::TX_STOP;
                next_st.tx_line = uart_core_pkg::LINE_IDLE;
              end
            end
          end
        end
      end
      uart_core_pkg::TX_NINTH: begin
        if (baud_tick) begin
          next_st.tx_tick = st.tx_tick + 4'h1;
          if (st.tx_tick == uart_core_pkg::TICK_LAST) begin
            next_st.tx_state = uart_core_pkg::TX_STOP;
            next_st.tx_line = uart_core_pkg::LINE_IDLE;
          end
        end
      end
      uart_core_pkg::TX_STOP: begin
        if (baud_tick) begin
          next_st.tx_tick = st.tx_tick + 4'h1;
          if (st.tx_tick == uart_core_pkg::TICK_LAST) begin
            // second stop bit only when asked for
            if (I_STOP_TWO && st.tx_bit == '0) begin
              next_st.tx_bit = 3'h1;
            end else begin
              next_st.tx_state = uart_core_pkg::TX_IDLE;
            end
          end
        end
      end
    endcase

    // a write while the holding register is full is dropped
    if (I_TX_WRITE && st.tx_holding_empty) begin
      next_st.tx_hold = I_TX_DATA;
      next_st.tx_hold_addr = I_OUTGOING_ADDR_FLAG;
      next_st.tx_holding_empty = 1'b0;
    end

    // receiver; only the first stop bit is checked
    unique case (st.rx_state)
      uart_core_pkg::RX_IDLE: begin
        // armed only after the line has been seen high, so a break does not retrigger
        next_st.rx_armed = st.rx_level;
        if (st.rx_armed && !st.rx_level && I_RX_ENABLE) begin
          next_st.rx_state = uart_core_pkg::RX_START;
          next_st.rx_tick = '0;
        end
      end
      uart_core_pkg::RX_START: begin
        if (baud_tick) begin
          next_st.rx_tick = st.rx_tick + 4'h1;
          if (st.rx_tick == uart_core_pkg::TICK_MID) begin
            // a glitch shorter than half a bit is not a start bit
            if (!st.rx_level) begin
              next_st.rx_state = uart_core_pkg::RX_DATA;
              next_st.rx_tick = '0;
              next_st.rx_bit = '0;
            end else begin
              next_st.rx_state = uart_core_pkg::RX_IDLE;
            end
          end
        end
      end
      uart_core_pkg::RX_DATA: begin
        if (baud_tick) begin
          next_st.rx_tick = st.rx_tick + 4'h1;
          if (st.rx_tick == uart_core_pkg::TICK_LAST) begin
            next_st.rx_shift = {st.rx_level, st.rx_shift[7:1]};
            next_st.rx_bit = st.rx_bit + 3'h1;
            if (st.rx_bit == uart_core_pkg::BIT_LAST) begin
              next_st.rx_state = ninth_used ? uart_core_pkg::RX_NINTH
                                            : uart_core_pkg::RX_STOP;
            end
          end
        end
      end
      uart_core_pkg::RX_NINTH: begin
        if (baud_tick) begin
          next_st.rx_tick = st.rx_tick + 4'h1;
          if (st.rx_tick == uart_core_pkg::TICK_LAST) begin
            next_st.rx_ninth = st.rx_level;
            next_st.rx_state = uart_core_pkg::RX_STOP;
          end
        end
      end
      uart_core_pkg::RX_STOP: begin
        if (baud_tick) begin
          next_st.rx_tick = st.rx_tick + 4'h1;
          if (st.rx_tick == uart_core_pkg::TICK_LAST) begin
            rx_done = 1'b1;
            next_st.rx_state = uart_core_pkg::RX_IDLE;
          end
        end
      end
    endcase

    // reading moves a waiting byte forward and clears the error flags
    if (I_RX_READ && st.rx_waiting) begin
      next_st.parity_err = 1'b0;
      next_st.framing_err = 1'b0;
      next_st.overrun_err = 1'b0;
      next_st.break_seen = 1'b0;
      if (st.pend_valid) begin
        next_st.rx_data = st.pend_data;
        next_st.rx_addr_bit = st.pend_addr;
        next_st.rx_new_frame = st.pend_new_frame;
        next_st.pend_valid = 1'b0;
      end else begin
        next_st.rx_waiting = 1'b0;
      end
    end

    // completed character: flags set after the read so a set wins over a clear
    if (rx_done) begin
      is_break = (st.rx_shift == 8'h00) && !st.rx_level && (!ninth_used || !st.rx_ninth);
      rx_is_addr = I_NINE_BIT_ENABLE && st.rx_ninth;
      if (is_break) begin
        next_st.break_seen = 1'b1;
        next_st.framing_err = 1'b1;
      end else begin
        if (!st.rx_level) begin
          next_st.framing_err = 1'b1;
        end
        if (I_PARITY_ENABLE_BIT && !I_NINE_BIT_ENABLE
            && st.rx_ninth != uart_core_pkg::parity_of(st.rx_shift, I_PARITY_ODD)) begin
          next_st.parity_err = 1'b1;
        end
        rx_accept = 1'b1;
        if (I_NINE_BIT_ENABLE) begin
          unique case (I_ADDR_SCHEME_FIELD)
            uart_core_pkg::SCHEME_ALL: rx_accept = 1'b1;
            uart_core_pkg::SCHEME_ADDR_ONLY: rx_accept = rx_is_addr;
            uart_core_pkg::SCHEME_MATCH, uart_core_pkg::SCHEME_MATCH_DATA: begin
              if (rx_is_addr) begin
                next_st.addr_matched = (st.rx_shift == I_NODE_ADDR);
                next_st.first_data = (st.rx_shift == I_NODE_ADDR);
                rx_accept = (st.rx_shift == I_NODE_ADDR)
                            && (I_ADDR_SCHEME_FIELD == uart_core_pkg::SCHEME_MATCH);
              end else begin
                rx_accept = st.addr_matched;
                rx_nf = st.first_data;
                next_st.first_data = 1'b0;
              end
            end
          endcase
        end
        if (rx_accept) begin
          if (!next_st.rx_waiting) begin
            next_st.rx_data = st.rx_shift;
            next_st.rx_addr_bit = rx_is_addr;
            next_st.rx_new_frame = rx_nf;
            next_st.rx_waiting = 1'b1;
          end else if (!next_st.pend_valid) begin
            next_st.pend_data = st.rx_shift;
            next_st.pend_addr = rx_is_addr;
            next_st.pend_new_frame = rx_nf;
            next_st.pend_valid = 1'b1;
          end else begin
            next_st.overrun_err = 1'b1;
          end
        end
      end
    end

    // interrupt requests, registered so they line up with the status flags
    next_st.tx_irq = next_st.tx_holding_empty && I_TX_IRQ_ENABLE;
    next_st.rx_irq = (next_st.rx_waiting && !I_RX_IRQ_ERRORS_ONLY)
                     || next_st.parity_err || next_st.framing_err
                     || next_st.overrun_err || next_st.break_seen;
  end

  // ---------------------------------------------------------------------------
  // state register; both directions share it but never each other's fields
  // ---------------------------------------------------------------------------
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      st <= ST_RESET;
    end else begin
      st <= next_st;
    end
  end

  // ---------------------------------------------------------------------------
  // outputs, all straight from the state register
  // ---------------------------------------------------------------------------
  assign O_TX_SERIAL = st.tx_line;
  assign O_TX_BUSY = (st.tx_state != uart_core_pkg::TX_IDLE);
  assign O_TX_HOLDING_EMPTY = st.tx_holding_empty;
  assign O_RX_BYTE_WAITING = st.rx_waiting;
  assign O_RX_DATA = st.rx_data;
  assign O_RX_ADDR_BIT = st.rx_addr_bit;
  assign O_RX_NEW_FRAME = st.rx_new_frame;
  assign O_PARITY_ERR = st.parity_err;
  assign O_FRAMING_ERR = st.framing_err;
  assign O_OVERRUN_ERR = st.overrun_err;
  assign O_BREAK_SEEN = st.break_seen;
  assign O_TX_IRQ = st.tx_irq;
  assign O_RX_IRQ = st.rx_irq;

endmodule

/* serial_core_monitor.sv */
// assertion checker on the serial core ports
`timescale 1ns/10ps
module serial_core_monitor (
  // clock and reset
  input wire logic I_CORE_CLK,
  input wire logic I_RST,
  // watched inputs
  input wire logic I_CTS_N,
  input wire logic I_TX_ENABLE_BIT,
  input wire logic I_FLOW_GATE_ENABLE,
  input wire logic I_TX_IRQ_ENABLE,
  input wire logic I_TX_WRITE,
  input wire logic I_RX_IRQ_ERRORS_ONLY,
  input wire logic I_RX_READ,
  // watched outputs
  input wire logic O_TX_SERIAL,
  input wire logic O_TX_HOLDING_EMPTY,
  input wire logic O_TX_BUSY,
  input wire logic O_RX_BYTE_WAITING,
  input wire logic [7:0] O_RX_DATA,
  input wire logic O_PARITY_ERR,
  input wire logic O_FRAMING_ERR,
  input wire logic O_OVERRUN_ERR,
  input wire logic O_TX_IRQ,
  input wire logic O_RX_IRQ
);
  // single clock domain
  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (I_RST);

  // transmit framing and gating
  AST_TX_IDLE_HIGH: assert property (!O_TX_BUSY |-> O_TX_SERIAL)
    else $error("tx low while idle");
  AST_TX_START_LOW: assert property ($rose(O_TX_BUSY) |-> !O_TX_SERIAL [*8])
    else $error("short start bit");
  AST_TX_ENABLE: assert property ($rose(O_TX_BUSY) |-> $past(I_TX_ENABLE_BIT))
    else $error("start while disabled");
  AST_CTS_HOLD: assert property ((I_FLOW_GATE_ENABLE && I_CTS_N) [*5] |=> !$rose(O_TX_BUSY))
    else $error("start while held off");
  AST_HOLD_FALL: assert property (I_TX_WRITE && O_TX_HOLDING_EMPTY && O_TX_BUSY |=> !O_TX_HOLDING_EMPTY)
    else $error("holding not full");
  AST_HOLD_RISE: assert property ($rose(O_TX_BUSY) |-> O_TX_HOLDING_EMPTY)
    else $error("holding not freed");
  AST_TX_IRQ: assert property (!$past(I_RST) |-> O_TX_IRQ == (O_TX_HOLDING_EMPTY && $past(I_TX_IRQ_ENABLE)))
    else $error("tx irq mismatch");
  // receive status and interrupt
  AST_RX_IRQ_DATA: assert property ($rose(O_RX_BYTE_WAITING) && !$past(I_RX_IRQ_ERRORS_ONLY) |-> O_RX_IRQ)
    else $error("no rx irq on byte");
  AST_RX_IRQ_ERRONLY: assert property ($past(I_RX_IRQ_ERRORS_ONLY) && !(O_PARITY_ERR || O_FRAMING_ERR || O_OVERRUN_ERR) |-> !O_RX_IRQ)
    else $error("rx irq without error");
  AST_ERR_STICKY: assert property (O_PARITY_ERR && !I_RX_READ |=> O_PARITY_ERR)
    else $error("parity flag lost");
  AST_WAIT_HOLD: assert property (O_RX_BYTE_WAITING && !I_RX_READ |=> O_RX_BYTE_WAITING && $stable(O_RX_DATA))
    else $error("byte changed unread");
endmodule

bind async_serial_txrx_core serial_core_monitor mon (.*);

/* serial_node_model.sv */
// remote serial node model
`timescale 1ns/10ps
module serial_node_model #(
  parameter int BIT_CLKS = 16
) (
  input wire logic clk,
  input wire logic tx_line,
  output logic rx_line,
  output logic cts_n
);
  logic [8:0] cap; // last decoded character, first wire bit in bit 0
  logic cap_stop;
  int n_caps = 0;
  int n_bits = 8;
  // idle high, clear-to-send granted
  initial begin
    rx_line = 1'b1;
    cts_n = 1'b0;
  end
  // decode each character mid bit
  always begin
    @(negedge tx_line);
    repeat (BIT_CLKS / 2) @(posedge clk);
    for (int i = 0; i < n_bits; i++) begin
      repeat (BIT_CLKS) @(posedge clk);
      cap[i] = tx_line;
    end
    repeat (BIT_CLKS) @(posedge clk);
    cap_stop = tx_line;
    n_caps++;
  end
  // one character, first bit first
  task automatic send(input logic [8:0] bits, input int nb, input logic stop);
    rx_line <= 1'b0;
    repeat (BIT_CLKS) @(posedge clk);
    for (int i = 0; i < nb; i++) begin
      rx_line <= bits[i];
      repeat (BIT_CLKS) @(posedge clk);
    end
    rx_line <= stop;
    repeat (BIT_CLKS) @(posedge clk);
    rx_line <= 1'b1;
  endtask
  // clear-to-send level
  task automatic hold_off(input logic h);
    cts_n <= h;
  endtask
endmodule

/* async_serial_txrx_core_tb_top.sv */
// testbench of the serial core
`timescale 1ns/10ps
module async_serial_txrx_core_tb_top;
  // ---------------------------------------------------------------------------
  // stimulus and observed signals
  // ---------------------------------------------------------------------------
  logic clk = 0, rst = 1, par_en = 0, par_odd = 0, stop2 = 0, nine = 0, tx_en = 1, gate = 0;
  logic mark = 0, tx_ie = 0, wr = 0, rx_en = 1, err_only = 0, rd = 0;
  logic [1:0] scheme = 2'h0;
  logic [7:0] txd = 8'h00, baud_hi = 8'h00, baud_lo = 8'h01, node_addr = 8'h5C;
  logic rx, cts_n, tx, hold, busy, wait_b, rx_addr, p_err, f_err, o_err, brk, tx_irq, rx_irq, nf;
  logic [7:0] rxd;
  int n_errors = 0;
  int comparisons = 0;
  always #12.5 clk = ~clk;
  // divisor one: sixteen clocks per bit
  async_serial_txrx_core dut (.I_CORE_CLK(clk), .I_RST(rst), .I_RX_SERIAL(rx), .I_CTS_N(cts_n),
    .O_TX_SERIAL(tx), .I_BAUD_HIGH(baud_hi), .I_BAUD_LOW(baud_lo), .I_PARITY_ENABLE_BIT(par_en),
    .I_PARITY_ODD(par_odd), .I_STOP_TWO(stop2), .I_NINE_BIT_ENABLE(nine),
    .I_ADDR_SCHEME_FIELD(scheme), .I_NODE_ADDR(node_addr), .I_TX_ENABLE_BIT(tx_en),
    .I_FLOW_GATE_ENABLE(gate), .I_OUTGOING_ADDR_FLAG(mark), .I_TX_IRQ_ENABLE(tx_ie),
    .I_TX_WRITE(wr), .I_TX_DATA(txd), .I_RX_ENABLE(rx_en), .I_RX_IRQ_ERRORS_ONLY(err_only),
    .I_RX_READ(rd), .O_TX_HOLDING_EMPTY(hold), .O_TX_BUSY(busy), .O_RX_BYTE_WAITING(wait_b),
    .O_RX_DATA(rxd), .O_RX_ADDR_BIT(rx_addr), .O_RX_NEW_FRAME(nf), .O_PARITY_ERR(p_err),
    .O_FRAMING_ERR(f_err), .O_OVERRUN_ERR(o_err), .O_BREAK_SEEN(brk), .O_TX_IRQ(tx_irq),
    .O_RX_IRQ(rx_irq));
  serial_node_model node (.clk(clk), .tx_line(tx), .rx_line(rx), .cts_n(cts_n));
  // ---------------------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------------------
  task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  task automatic end_sim;
    $display("comparisons %0d, mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // read outputs mid cycle
  task automatic settle;
    @(negedge clk);
  endtask
  task automatic do_reset;
    rst <= 1'b1;
    cyc(3);
    rst <= 1'b0;
    cyc(4);
  endtask
  // write pulse, then a free edge
  task automatic pulse(input logic [7:0] d);
    wr <= 1'b1;
    txd <= d;
    cyc(1);
    wr <= 1'b0;
    cyc(1);
  endtask
  task automatic read_pulse;
    rd <= 1'b1;
    cyc(1);
    rd <= 1'b0;
    cyc(1);
  endtask
  task automatic wait_caps(input int n);
    for (int i = 0; i < 600 && node.n_caps < n; i++) cyc(1);
  endtask
  task automatic tx_one(input logic [7:0] d, input logic [8:0] exp, input int nb);
    int c0;
    c0 = node.n_caps;
    node.n_bits = nb;
    pulse(d);
    wait_caps(c0 + 1);
    check("tx char", nb == 8 ? {1'b0, node.cap[7:0]} : node.cap, exp);
    check("tx stop", node.cap_stop, 1'b1);
  endtask
  // ---------------------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------------------
  task automatic t_reset;
    settle;
    check("hold empty", hold, 1'b1);
    check("byte waiting", wait_b, 1'b0);
    check("tx line", tx, 1'b1);
    cyc(1);
    $display("test reset done");
  endtask
  task automatic t_formats;
    tx_one(8'h35, 9'h035, 8);
    par_en <= 1'b1;
    for (int k = 0; k < 2; k++) begin
      par_odd <= k[0];
      tx_one(8'h34, {^8'h34 ^ k[0], 8'h34}, 9);
    end
    nine <= 1'b1;
    stop2 <= 1'b1;
    for (int k = 0; k < 2; k++) begin
      mark <= k[0];
      tx_one(8'hC3, {k[0], 8'hC3}, 9);
    end
    nine <= 1'b0;
    stop2 <= 1'b0;
    par_en <= 1'b0;
    par_odd <= 1'b0;
    $display("test formats done");
  endtask
  task automatic t_back2back;
    int c0;
    c0 = node.n_caps;
    node.n_bits = 8;
    pulse(8'h11);
    for (int i = 0; i < 100 && hold !== 1'b1; i++) cyc(1);
    pulse(8'h22);
    settle;
    check("hold full", hold, 1'b0);
    cyc(1);
    pulse(8'h33);
    wait_caps(c0 + 2);
    check("second char", {1'b0, node.cap[7:0]}, 9'h022);
    cyc(250);
    check("char count", 9'(node.n_caps - c0), 9'h002);
    $display("test back to back done");
  endtask
  task automatic t_gate;
    int c0;
    tx_en <= 1'b0;
    tx_ie <= 1'b1;
    cyc(2);
    settle;
    check("tx irq empty", tx_irq, 1'b1);
    cyc(1);
    c0 = node.n_caps;
    node.n_bits = 8;
    pulse(8'h5A);
    cyc(100);
    settle;
    check("chars while off", 9'(node.n_caps - c0), 9'h000);
    check("tx irq full", tx_irq, 1'b0);
    cyc(1);
    node.hold_off(1'b1);
    cyc(5);
    gate <= 1'b1;
    tx_en <= 1'b1;
    cyc(100);
    check("chars while held", 9'(node.n_caps - c0), 9'h000);
    node.hold_off(1'b0);
    wait_caps(c0 + 1);
    check("gated char", {1'b0, node.cap[7:0]}, 9'h05A);
    node.hold_off(1'b1);
    gate <= 1'b0;
    tx_one(8'hA6, 9'h0A6, 8);
    node.hold_off(1'b0);
    tx_ie <= 1'b0;
    $display("test gate done");
  endtask
  task automatic t_rx;
    node.send(9'h03C, 8, 1'b1);
    for (int i = 0; i < 100 && wait_b !== 1'b1; i++) cyc(1);
    settle;
    check("rx data", rxd, 9'h03C);
    check("rx irq", rx_irq, 1'b1);
    cyc(1);
    read_pulse;
    settle;
    check("waiting after read", wait_b, 1'b0);
    cyc(1);
    node.send(9'h081, 8, 1'b1);
    node.send(9'h07E, 8, 1'b1);
    cyc(8);
    read_pulse;
    settle;
    check("waiting pending", wait_b, 1'b1);
    check("pending data", rxd, 9'h07E);
    cyc(1);
    read_pulse;
    rx_en <= 1'b0;
    cyc(1);
    node.send(9'h0AA, 8, 1'b1);
    cyc(20);
    settle;
    check("rx while off", wait_b, 1'b0);
    cyc(1);
    rx_en <= 1'b1;
    $display("test receive done");
  endtask
  task automatic t_rx_err;
    err_only <= 1'b1;
    par_en <= 1'b1;
    cyc(1);
    node.send(9'h055, 9, 1'b1);
    cyc(8);
    settle;
    check("good parity", {wait_b, p_err}, 9'h002);
    check("irq errors only", rx_irq, 1'b0);
    cyc(1);
    read_pulse;
    node.send(9'h155, 9, 1'b1);
    cyc(8);
    settle;
    check("bad parity", p_err, 1'b1);
    check("irq on error", rx_irq, 1'b1);
    cyc(1);
    read_pulse;
    node.send(9'h000, 9, 1'b0);
    cyc(40);
    settle;
    check("break flags", {brk, f_err}, 9'h003);
    cyc(1);
    err_only <= 1'b0;
    par_en <= 1'b0;
    $display("test receive errors done");
  endtask
  task automatic t_scheme;
    nine <= 1'b1;
    scheme <= 2'h1;
    cyc(1);
    node.send(9'h012, 9, 1'b1);
    node.send(9'h1A7, 9, 1'b1);
    cyc(8);
    settle;
    check("address only", {rx_addr, rxd}, 9'h1A7);
    cyc(1);
    read_pulse;
    scheme <= 2'h3;
    node.send(9'h15C, 9, 1'b1);
    node.send(9'h03E, 9, 1'b1);
    cyc(8);
    settle;
    check("new frame", {nf, rxd}, 9'h13E);
    cyc(1);
    $display("test scheme done");
  endtask
  // main sequence
  initial begin
    cyc(10);
    rst <= 1'b0;
    cyc(4);
    t_reset;
    t_formats;
    t_back2back;
    t_gate;
    t_rx;
    t_rx_err;
    do_reset;
    t_scheme;
    end_sim;
  end
  // watchdog far past the expected run
  initial begin
    cyc(30000);
    n_errors++;
    end_sim;
  end
endmodule
